// [pkg/ssar_pkg.sv]
package ssar_pkg;

    // Frame layout on the serial output
    localparam int unsigned FRAME_BITS = 16;
    localparam int unsigned LEAD_ZEROS = 4;
    localparam int unsigned RES_BITS   = 12;

    // Falling-edge numbers within a frame (edge 1 is the first after select falls)
    localparam logic [4:0] EDGE_TRIAL_MSB = 5'h03;  // Last leading zero, first trial set
    localparam logic [4:0] EDGE_FIRST_BIT = 5'h04;  // MSB decided and shown
    localparam logic [4:0] EDGE_LAST_BIT  = 5'h0F;  // LSB decided and shown
    localparam logic [4:0] EDGE_RELEASE   = 5'h10;  // Output released
    localparam logic [4:0] EDGE_CNT_RST   = 5'h00;

    // Result reset value and first trial code
    localparam logic [11:0] CODE_RST      = 12'h000;
    localparam logic [11:0] TRIAL_MSB     = 12'h800;

    // Result FIFO geometry
    localparam int unsigned FIFO_DEPTH    = 32;

    // Driver turn-on after select falls: longest time, rounded down, at least one cycle
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned T_DRIVE_NS    = 20;
    localparam int unsigned DRIVE_CYC_RAW = T_DRIVE_NS / CLK_PERIOD_NS;
    localparam int unsigned DRIVE_CYC     = (DRIVE_CYC_RAW < 1) ? 1 : DRIVE_CYC_RAW;

    // Frame sequencer states
    typedef enum logic [1:0] {
        SSAR_IDLE   = 2'b00,
        SSAR_ACTIVE = 2'b01,
        SSAR_DONE   = 2'b10
    } ssar_state_e;

    // One finished conversion as it travels through the FIFO
    typedef struct packed {
        logic [11:0] code;
        logic        late;   // Set when the previous result was dropped
    } ssar_result_s;

endpackage

// [verilog/ssar_fifo.sv]
`timescale 1ns/100ps
module ssar_fifo #(
    parameter int unsigned WIDTH = 13,
    parameter int unsigned DEPTH = 32
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wr_ptr_q;
    logic [AW:0]      rd_ptr_q;
    logic             push;
    logic             pop;

    // Extra pointer bit tells full from empty
    assign in_ready  = !((wr_ptr_q[AW] != rd_ptr_q[AW]) && (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]));
    assign out_valid = (wr_ptr_q != rd_ptr_q);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_q[rd_ptr_q[AW-1:0]];

    // Storage, no reset needed on data
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_ptr_q[AW-1:0]] <= in_data;
        end
    end

    // Write pointer
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_ptr_q <= '0;
        end else if (push) begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
        end
    end

    // Read pointer
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_ptr_q <= '0;
        end else if (pop) begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
        end
    end

endmodule // ssar_fifo

// [verilog/ssar_readout.sv]
`timescale 1ns/100ps
// Operation
// - A falling select both starts a new conversion and opens the serial frame carrying its result.
// - The serial result output changes on each falling edge of the serial clock, one new bit per edge.
// - Each frame sends four zero bits first, then the twelve result bits MSB first.
// - The result is plain unsigned binary, zero for the lowest input and rising with the input.
// - The conversion steps are paced by the serial clock, so the host must keep it toggling all frame.
// - The serial output stays released until select falls and is driven shortly after that.
// - The serial output is released again after the falling edge that ends the transfer.
module ssar_readout (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  cs_n,
    input  wire logic                  sclk,
    input  wire logic                  comp_in,
    output logic                       track_hold,
    output logic                [11:0] dac_code,
    output logic                       serial_result_out,
    output logic                       serial_result_oe,
    output logic                       busy,
    output logic                       frame_abort,
    output logic                       result_space,
    output logic                       result_valid,
    input  wire logic                  result_ready,
    output ssar_pkg::ssar_result_s     result_data
);

    ssar_pkg::ssar_state_e state_q;
    logic                  cs_n_q;
    logic                  sclk_q;
    logic                  cs_fall;
    logic                  cs_rise;
    logic                  sclk_fall;
    logic [4:0]            edge_cnt_q;
    logic [4:0]            edge_num;
    logic [11:0]           code_q;
    logic [11:0]           dac_q;
    logic                  sout_q;
    logic                  soe_q;
    logic                  push_q;
    logic                  late_q;
    logic                  abort_q;
    logic                  fifo_in_ready;
    logic                  bit_edge;
    logic [3:0]            bit_idx;
    ssar_pkg::ssar_result_s push_data_q;

    // Bit position decided at a given falling edge: edge 4 gives bit 11, edge 15 bit 0
    function automatic logic [3:0] ssar_bit_index(input logic [4:0] n);
        logic [4:0] idx;
        idx = 5'h0F - n;
        return idx[3:0];
    endfunction

    // Input history for edge detection; pins are already in the clk domain
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cs_n_q <= 1'b1;
            sclk_q <= 1'b1;
        end else begin
            cs_n_q <= cs_n;
            sclk_q <= sclk;
        end
    end

    assign cs_fall   = cs_n_q && !cs_n;
    assign cs_rise   = !cs_n_q && cs_n;
    assign sclk_fall = sclk_q && !sclk && !cs_n;
    assign edge_num  = edge_cnt_q + 5'h01;
    assign bit_edge  = (state_q == ssar_pkg::SSAR_ACTIVE) && sclk_fall
                       && (edge_num >= ssar_pkg::EDGE_FIRST_BIT) && (edge_num <= ssar_pkg::EDGE_LAST_BIT);
    assign bit_idx   = ssar_bit_index(edge_num);

    // Frame sequencer; select rising mid-frame abandons the conversion
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= ssar_pkg::SSAR_IDLE;
        end else begin
            case (state_q)
                ssar_pkg::SSAR_IDLE: begin
                    if (cs_fall) begin
                        state_q <= ssar_pkg::SSAR_ACTIVE;
                    end
                end
                ssar_pkg::SSAR_ACTIVE: begin
                    if (cs_rise) begin
                        state_q <= ssar_pkg::SSAR_IDLE;
                    end else if (sclk_fall && edge_num == ssar_pkg::EDGE_RELEASE) begin
                        state_q <= ssar_pkg::SSAR_DONE;
                    end
                end
                ssar_pkg::SSAR_DONE: begin
                    if (cs_rise) begin
                        state_q <= ssar_pkg::SSAR_IDLE;  // Next frame needs select high first
                    end
                end
                default: begin
                    state_q <= ssar_pkg::SSAR_IDLE;
                end
            endcase
        end
    end

    // Falling-edge counter paces the whole conversion
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            edge_cnt_q <= ssar_pkg::EDGE_CNT_RST;
        end else if (state_q != ssar_pkg::SSAR_ACTIVE) begin
            edge_cnt_q <= ssar_pkg::EDGE_CNT_RST;
        end else if (sclk_fall) begin
            edge_cnt_q <= edge_num;
        end
    end

    // Trial code to the capacitive DAC, one bit per generate slice
    generate
        for (genvar gi = 0; gi < ssar_pkg::RES_BITS; gi++) begin : g_trial
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    dac_q[gi] <= 1'b0;
                end else if (cs_fall && state_q == ssar_pkg::SSAR_IDLE) begin
                    dac_q[gi] <= 1'b0;
                end else if (state_q == ssar_pkg::SSAR_ACTIVE && sclk_fall
                             && edge_num == ssar_pkg::EDGE_TRIAL_MSB) begin
                    dac_q[gi] <= ssar_pkg::TRIAL_MSB[gi];
                end else if (bit_edge) begin
                    if (bit_idx == 4'(gi)) begin
                        dac_q[gi] <= comp_in;  // Keep trial only if input is at or above it
                    end else if (bit_idx == 4'(gi + 1)) begin
                        dac_q[gi] <= 1'b1;  // Try the next lower weight
                    end
                end
            end
        end
    endgenerate

    // Result word; comparator high means input at or above the trial, so codes rise with input
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            code_q <= ssar_pkg::CODE_RST;
        end else if (cs_fall && state_q == ssar_pkg::SSAR_IDLE) begin
            code_q <= ssar_pkg::CODE_RST;
        end else if (bit_edge) begin
            code_q[bit_idx] <= comp_in;
        end
    end

    // Serial data: zeros, then decided bits, one per falling edge
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sout_q <= 1'b0;
        end else if (cs_fall && state_q == ssar_pkg::SSAR_IDLE) begin
            sout_q <= 1'b0;  // First leading zero appears with the driver
        end else if (bit_edge) begin
            sout_q <= comp_in;  // MSB first as bit_idx walks down
        end else if (state_q == ssar_pkg::SSAR_ACTIVE && sclk_fall) begin
            sout_q <= 1'b0;  // Remaining leading zeros
        end
    end

    // Output driver: one cycle after select falls, 100 ns at this rate, past the 20 ns turn-on budget
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            soe_q <= 1'b0;
        end else if (cs_fall && state_q == ssar_pkg::SSAR_IDLE) begin
            soe_q <= 1'b1;
        end else if (cs_rise) begin
            soe_q <= 1'b0;
        end else if (state_q == ssar_pkg::SSAR_ACTIVE && sclk_fall && edge_num == ssar_pkg::EDGE_RELEASE) begin
            soe_q <= 1'b0;
        end
    end

    // Finished result into the FIFO; a full FIFO drops it and marks the next one late
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            push_q      <= 1'b0;
            push_data_q <= '0;
        end else if (bit_edge && edge_num == ssar_pkg::EDGE_LAST_BIT) begin
            push_q           <= 1'b1;
            push_data_q.code <= {code_q[11:1], comp_in};
            push_data_q.late <= late_q;
        end else begin
            push_q <= 1'b0;
        end
    end

    // Drop marker; set by a drop, cleared again by the next successful push
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            late_q <= 1'b0;
        end else if (push_q && !fifo_in_ready) begin
            late_q <= 1'b1;
        end else if (push_q) begin
            late_q <= 1'b0;
        end
    end

    // One-cycle pulse when select rises before the frame completed
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            abort_q <= 1'b0;
        end else begin
            abort_q <= cs_rise && (state_q == ssar_pkg::SSAR_ACTIVE);
        end
    end

    ssar_fifo #(
        .WIDTH ($bits(ssar_pkg::ssar_result_s)),
        .DEPTH (ssar_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (push_q),
        .in_ready  (fifo_in_ready),
        .in_data   (push_data_q),
        .out_valid (result_valid),
        .out_ready (result_ready),
        .out_data  (result_data)
    );

    // Hold phase lasts while a conversion is running
    assign track_hold        = (state_q != ssar_pkg::SSAR_ACTIVE);
    assign dac_code          = dac_q;
    assign serial_result_out = sout_q;
    assign serial_result_oe  = soe_q;
    assign busy              = (state_q == ssar_pkg::SSAR_ACTIVE);
    assign frame_abort       = abort_q;
    assign result_space      = fifo_in_ready;

endmodule // ssar_readout

// [dv/ssar_readout_assertions.sv]
`timescale 1ns/100ps
module ssar_readout_chk (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        cs_n,
    input wire logic        sclk,
    input wire logic        comp_in,
    input wire logic [11:0] dac_code,
    input wire logic        serial_result_out,
    input wire logic        serial_result_oe,
    input wire logic        busy,
    input wire logic        track_hold
);
    logic       sclk_q;
    logic [4:0] falls_q;
    logic       fall;

    // Counted serial clock fall inside a frame
    assign fall = busy && !cs_n && !sclk && sclk_q;

    // Own fall count, cleared whenever no frame runs
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sclk_q  <= 1'b1;
            falls_q <= 5'h00;
        end else begin
            sclk_q  <= sclk;
            falls_q <= busy ? falls_q + {4'h0, fall} : 5'h00;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_cs_start: assert property ((!busy && !serial_result_oe && !cs_n && $past(cs_n)) |=>
        busy && serial_result_oe && !serial_result_out) else $error("select fall did not open a frame");
    a_oe_frame: assert property (serial_result_oe |-> busy)
        else $error("output driven outside a frame");
    a_hold_high: assert property ((busy && !cs_n && sclk) |=> $stable(serial_result_out))
        else $error("output changed without a clock fall");
    a_lead_zero: assert property ((fall && falls_q < 5'h03) |=> !serial_result_out)
        else $error("leading bit not zero");
    a_trial_msb: assert property ((fall && falls_q == 5'h02) |=> dac_code == 12'h800)
        else $error("first trial code wrong");
    a_bit_decide: assert property ((fall && falls_q >= 5'h03 && falls_q < 5'h0F) |=>
        serial_result_out == $past(comp_in)) else $error("result bit not the decision");
    a_out_release: assert property ((fall && falls_q == 5'h0F) |=> !serial_result_oe [*2])
        else $error("output not released after last fall");
    a_hold_convert: assert property (busy |-> !track_hold)
        else $error("track phase during a conversion");
endmodule // ssar_readout_chk

bind ssar_readout ssar_readout_chk ssar_readout_chk_i (.clk, .rst_n, .cs_n, .sclk, .comp_in, .dac_code,
    .serial_result_out, .serial_result_oe, .busy, .track_hold);

// [dv/ssar_host.sv]
`timescale 1ns/100ps
module ssar_host (
    input wire logic        clk,
    input wire logic [11:0] dac_code,
    input wire logic        sd_out,
    input wire logic        sd_oe,
    output logic            cs_n,
    output logic            sclk,
    output logic            comp_in
);
    logic [11:0] vin;
    logic        last_q;
    logic        line_lvl;

    initial begin
        cs_n = 1'b1;
        sclk = 1'b1;
        vin  = 12'h000;
        last_q = 1'b0;
    end

    // Released line shows the inverse of the last bit, never a lucky match
    always @(posedge clk) if (sd_oe) last_q <= sd_out;
    assign line_lvl = sd_oe ? sd_out : ~last_q;
    // Ideal comparator against the held input, straight binary
    assign comp_in = (vin >= dac_code);

    // One frame; fewer than 16 falls makes an early select rise
    task automatic frame(input logic [11:0] v, input int falls, input int gap, output logic [15:0] word);
        word = 16'h0000;
        @(posedge clk);
        vin  <= v;
        cs_n <= 1'b0;
        @(posedge clk);
        for (int k = 0; k < falls; k++) begin
            repeat (gap) @(posedge clk);
            @(posedge clk);
            word = {word[14:0], line_lvl};
            sclk <= 1'b0;
            @(posedge clk);
            sclk <= 1'b1;
        end
        @(posedge clk);
        cs_n <= 1'b1;
        repeat (2) @(posedge clk);  // Second edge lets an abort's release settle before callers look
    endtask
endmodule // ssar_host

// [dv/test_ssar_readout.sv]
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module test_ssar_readout;
    logic clk, rst_n, cs_n, sclk, comp_in, track_hold, serial_result_out, serial_result_oe;
    logic busy, frame_abort, result_space, result_valid, result_ready;
    logic [11:0]            dac_code;
    logic [15:0]            word;
    ssar_pkg::ssar_result_s result_data;
    int                     num_errors = 0;
    int                     n_checks = 0;
    int                     n_aborts = 0;
    int                     cycles = 0;
    logic [11:0]            vals [6] = '{12'h000, 12'hFFF, 12'h800, 12'h7FF, 12'hA5C, 12'h001};

    ssar_readout ssar_readout_i (.clk, .rst_n, .cs_n, .sclk, .comp_in, .track_hold, .dac_code, .serial_result_out,
        .serial_result_oe, .busy, .frame_abort, .result_space, .result_valid, .result_ready, .result_data);
    ssar_host ssar_host_i (.clk, .dac_code, .sd_out(serial_result_out), .sd_oe(serial_result_oe), .cs_n, .sclk,
        .comp_in);

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Hang guard, a few times the expected run
    always @(posedge clk) begin
        cycles++;
        if (cycles == 8000) begin
            num_errors++;
            give_verdict();
        end
    end

    // Abort pulses seen on the output, one count per standing cycle
    always @(posedge clk) begin
        if (frame_abort === 1'b1) begin
            n_aborts++;
        end
    end

    task automatic run_frame(input logic [11:0] v, input int gap);
        ssar_host_i.frame(v, 16, gap, word);
        `CHK(word, {4'h0, v})
        `CHK(serial_result_oe, 1'b0)
        `CHK(track_hold, 1'b1)
    endtask

    // Waits bounded for a stored word, checks it, pops it
    task automatic pop_check(input logic [11:0] code, input logic late);
        for (int n = 0; n < 50 && result_valid !== 1'b1; n++) @(posedge clk);
        `CHK(result_valid, 1'b1)
        `CHK(result_data.code, code)
        `CHK(result_data.late, late)
        result_ready <= 1'b1;
        @(posedge clk);
        result_ready <= 1'b0;
        @(posedge clk);  // Pointer moves on the pop edge; look again only after it
    endtask

    task automatic t_codes();
        `CHK(serial_result_oe, 1'b0)
        `CHK(track_hold, 1'b1)
        foreach (vals[i]) begin
            run_frame(vals[i], 0);
            pop_check(vals[i], 1'b0);
        end
        `CHK(n_aborts, 0)
    endtask

    // Clock paused high mid-frame; result must still come out whole
    task automatic t_stall();
        run_frame(12'h3C9, 4);
        pop_check(12'h3C9, 1'b0);
    endtask

    // Early select rise stores nothing, next frame is clean
    task automatic t_abort();
        ssar_host_i.frame(12'hB00, 8, 0, word);
        `CHK(word[7:0], 8'h0B)
        `CHK(result_valid, 1'b0)
        `CHK(serial_result_oe, 1'b0)
        run_frame(12'h5A5, 0);
        pop_check(12'h5A5, 1'b0);
        `CHK(n_aborts, 1)
    endtask

    // Consumer stalls until the store refuses, then drains it
    task automatic t_fill();
        for (int i = 0; i < 33; i++) run_frame(12'h100 + i[11:0], 0);
        `CHK(result_space, 1'b0)
        for (int i = 0; i < 32; i++) pop_check(12'h100 + i[11:0], 1'b0);
        `CHK(result_valid, 1'b0)
        run_frame(12'h0AA, 0);
        pop_check(12'h0AA, 1'b1);
    endtask

    initial begin
        rst_n = 1'b0;
        result_ready = 1'b0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_codes();
        t_stall();
        t_abort();
        t_fill();
        give_verdict();
    end
endmodule // test_ssar_readout
